// File: design/usb_host_register_map.sv
// Purpose: register bank of a single-port usb host controller on a 16-bit parallel bus
// Assumes: processor holds cs_n low across each strobe; writes land on the wr_n rising edge
// Notes:   pins pass a two-flop synchroniser, so strobes must stay low for 3+ clocks
//
// Behaviour
// - upper half of capability word reads interface version 0x0100, bcd major.minor
// - lowest byte of capability word reads capability length 0x10
// - structural word reads one port in bits 3:0, zero above
// - periodic list base at 0x24 resets to zero
// - async list pointer at 0x28 resets to zero
// - port status and control at 0x30 resets to zero
// - frame end timing at 0x34 resets to 0x00000041
// - edge irq control at 0x88 resets to 0x0000001f
// - transfer length at 0x94 resets to zero
// - aux buffer address at 0x98 resets to zero
// - aux buffer data at 0x9a resets to zero
// - controller irq status at 0xa0 resets to zero
// - controller irq enable at 0xa4 resets to zero
// - usb interrupt enable at 0x18 resets to zero
// - test parameter one 0x70 and two 0x74 reset to zero
`timescale 1ns/1ns
`default_nettype none
module usb_host_register_map
  import usb_host_reg_pkg::*;
#(
  parameter logic [31:0] DEVICE_IDENTITY = 32'h5a5a_0001, // arbitrary value
  parameter int          BUF_WORDS       = 256
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // processor bus strobes and address
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic [ADDR_W-1:0] addr,
  // processor data, three signals of the two-way bus
  input  wire logic [DATA_W-1:0] data_in,
  output var  logic [DATA_W-1:0] data_out,
  output var  logic              data_oe
);

  localparam int BUF_AW = $clog2(BUF_WORDS);

  bus_pins_t         pins_raw;
  bus_pins_t         pins;
  bus_pins_t         pins_prev;
  logic [$bits(bus_pins_t)-1:0] sync_bits;
  logic              write_pulse;
  logic              read_end;
  logic              read_active;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] next_read_data;
  logic              after_reset;

  logic [31:0]       word_reg   [WORD_COUNT];
  logic [15:0]       half_reg   [HALF_COUNT];
  logic [15:0]       ch_pointer [CHANNELS];
  logic [15:0]       ch_window  [CHANNELS];
  logic              ch_fetch   [CHANNELS];
  logic [15:0]       buf_mem    [BUF_WORDS];

  // halfword-aligned view of an address
  function automatic logic [ADDR_W-1:0] even_of(input logic [ADDR_W-1:0] a);
    even_of = {a[ADDR_W-1:1], 1'b0};
  endfunction : even_of

  // slot of a 32-bit storage register, or -1
  function automatic int word_slot(input logic [ADDR_W-1:0] a);
    word_slot = -1;
    for (int i = 0; i < WORD_COUNT; i++)
    begin
      if (a[ADDR_W-1:2] == WORD_OFFSET[i][ADDR_W-1:2])
      begin
        word_slot = i;
      end
    end
  endfunction : word_slot

  // slot of a 16-bit storage register, or -1
  function automatic int half_slot(input logic [ADDR_W-1:0] a);
    half_slot = -1;
    for (int i = 0; i < HALF_COUNT; i++)
    begin
      if (even_of(a) == HALF_OFFSET[i])
      begin
        half_slot = i;
      end
    end
  endfunction : half_slot

  function automatic logic [15:0] half_of(input logic [31:0] w, input logic upper);
    half_of = upper ? w[31:16] : w[15:0];
  endfunction : half_of

  function automatic logic [BUF_AW-1:0] mem_index(input logic [15:0] ptr);
    mem_index = ptr[BUF_AW:1];
  endfunction : mem_index

  // bus pins, cross into ref_clk before anything reads them
  assign pins_raw = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, addr: addr, data: data_in};

  pin_sync #(
    .WIDTH ($bits(bus_pins_t)),
    .IDLE  (BUS_IDLE)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in (pins_raw),
    .sync_out (sync_bits)
  );

  assign pins = bus_pins_t'(sync_bits);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pins_prev <= BUS_IDLE;
    end
    else
    begin
      pins_prev <= pins;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      after_reset <= 1'b1;
    end
    else
    begin
      after_reset <= 1'b0;
    end
  end

  // address and data are taken from the last sample with wr_n still low,
  // since the rising edge sample may already hold the next cycle
  assign write_pulse = !pins_prev.cs_n && !pins_prev.wr_n && pins.wr_n;
  assign read_end    = !pins_prev.cs_n && !pins_prev.rd_n && pins.rd_n;
  assign read_active = !pins.cs_n && !pins.rd_n;
  assign wr_addr     = pins_prev.addr;
  assign wr_data     = pins_prev.data;

  // plain 32-bit storage, written one halfword at a time
  genvar gw;
  generate
    for (gw = 0; gw < WORD_COUNT; gw++)
    begin : g_word
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          word_reg[gw] <= WORD_RESET[gw];
        end
        else if (write_pulse && word_slot(wr_addr) == gw)
        begin
          if (wr_addr[HALF_SEL_BIT])
          begin
            word_reg[gw][31:16] <= wr_data;
          end
          else
          begin
            word_reg[gw][15:0] <= wr_data;
          end
        end
      end
    end
  endgenerate

  // plain 16-bit storage
  genvar gh;
  generate
    for (gh = 0; gh < HALF_COUNT; gh++)
    begin : g_half
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          half_reg[gh] <= HALF_RESET[gh];
        end
        else if (write_pulse && half_slot(wr_addr) == gh)
        begin
          half_reg[gh] <= wr_data;
        end
      end
    end
  endgenerate

  // buffer windows: each data-port access moves the pointer one word and refetches,
  // so a read returns the word the pointer names after the channel's last access, or zero until the first one after reset
  genvar gc;
  generate
    for (gc = 0; gc < CHANNELS; gc++)
    begin : g_channel
      logic addr_write;
      logic data_write;
      logic data_read;

      assign addr_write = write_pulse && even_of(wr_addr) == CH_ADDR_OFF[gc];
      assign data_write = write_pulse && even_of(wr_addr) == CH_DATA_OFF[gc];
      assign data_read  = read_end && even_of(pins_prev.addr) == CH_DATA_OFF[gc];

      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          ch_pointer[gc] <= '0;
        end
        else if (addr_write)
        begin
          ch_pointer[gc] <= wr_data;
        end
        else if (data_write || data_read)
        begin
          ch_pointer[gc] <= ch_pointer[gc] + POINTER_STEP;
        end
      end

      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          ch_fetch[gc] <= 1'b0;
        end
        else
        begin
          ch_fetch[gc] <= addr_write || data_write || data_read;
        end
      end

      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          ch_window[gc] <= '0;
        end
        else if (ch_fetch[gc])
        begin
          ch_window[gc] <= buf_mem[mem_index(ch_pointer[gc])];
        end
      end
    end
  endgenerate

  // shared buffer; only one bus access can be in flight, so one writer per cycle
  always_ff @(posedge ref_clk)
  begin
    if (write_pulse && even_of(wr_addr) == OFF_BUFFER_DATA)
    begin
      buf_mem[mem_index(ch_pointer[0])] <= wr_data;
    end
    else if (write_pulse && even_of(wr_addr) == OFF_AUX_BUFFER_DATA)
    begin
      buf_mem[mem_index(ch_pointer[1])] <= wr_data;
    end
  end

  // read mux; capability words have no storage, so writes to them vanish
  always_comb
  begin
    int ws;
    int hs;
    logic [ADDR_W-1:0] a;
    ws = word_slot(pins.addr);
    hs = half_slot(pins.addr);
    a  = even_of(pins.addr);
    next_read_data = '0;
    if (ws >= 0)
    begin
      next_read_data = half_of(word_reg[ws], pins.addr[HALF_SEL_BIT]);
    end
    else if (hs >= 0)
    begin
      next_read_data = half_reg[hs];
    end
    else
    begin
      case (a)
        OFF_CAP_LENGTH_VERSION:
          next_read_data = {8'h00, CAPABILITY_LENGTH};
        OFF_CAP_LENGTH_VERSION | OFF_HIGH_HALF:
          next_read_data = INTERFACE_VERSION;
        OFF_STRUCTURAL_PARAMS:
          next_read_data = {12'h000, PORT_COUNT};
        OFF_CAPABILITY_PARAMS:
          next_read_data = CAPABILITY_PARAMS[15:0];
        OFF_CAPABILITY_PARAMS | OFF_HIGH_HALF:
          next_read_data = CAPABILITY_PARAMS[31:16];
        OFF_DEVICE_IDENTITY:
          next_read_data = DEVICE_IDENTITY[15:0];
        OFF_DEVICE_IDENTITY | OFF_HIGH_HALF:
          next_read_data = DEVICE_IDENTITY[31:16];
        OFF_BUFFER_ADDRESS:
          next_read_data = ch_pointer[0];
        OFF_BUFFER_DATA:
          next_read_data = ch_window[0];
        OFF_AUX_BUFFER_ADDRESS:
          next_read_data = ch_pointer[1];
        OFF_AUX_BUFFER_DATA:
          next_read_data = ch_window[1];
        default:
          next_read_data = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end
    else
    begin
      data_out <= next_read_data;
      data_oe  <= read_active;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence read_at(logic [ADDR_W-1:0] off);
    read_active && even_of(pins.addr) == off;
  endsequence

  sequence write_at(logic [ADDR_W-1:0] off);
    write_pulse && even_of(wr_addr) == off;
  endsequence

  version_read_a : assert property (
    read_at(OFF_CAP_LENGTH_VERSION | OFF_HIGH_HALF) |=> data_oe && data_out == INTERFACE_VERSION)
    else $error("interface version read wrong");

  cap_length_read_a : assert property (
    read_at(OFF_CAP_LENGTH_VERSION) |=> data_oe && data_out == {8'h00, CAPABILITY_LENGTH})
    else $error("capability length read wrong");

  port_count_read_a : assert property (
    read_at(OFF_STRUCTURAL_PARAMS) |=> data_out == {12'h000, PORT_COUNT})
    else $error("port count read wrong");

  periodic_reset_a : assert property (
    after_reset |-> word_reg[IDX_PERIODIC] == '0)
    else $error("periodic list base not zero after reset");

  async_reset_a : assert property (
    after_reset |-> word_reg[IDX_ASYNC] == '0)
    else $error("async list pointer not zero after reset");

  port_reset_a : assert property (
    after_reset |-> word_reg[IDX_PORT] == '0)
    else $error("port status not zero after reset");

  frame_end_reset_a : assert property (
    after_reset |-> word_reg[IDX_FRAME_END] == WORD_RESET[IDX_FRAME_END])
    else $error("frame end timing reset value wrong");

  edge_irq_reset_a : assert property (
    after_reset |-> word_reg[IDX_EDGE_IRQ] == WORD_RESET[IDX_EDGE_IRQ])
    else $error("edge irq control reset value wrong");

  length_reset_a : assert property (
    after_reset |-> half_reg[IDX_XFER_LENGTH] == '0)
    else $error("transfer length not zero after reset");

  aux_address_reset_a : assert property (
    after_reset |-> ch_pointer[1] == '0)
    else $error("aux buffer address not zero after reset");

  aux_data_reset_a : assert property (
    after_reset |-> ch_window[1] == '0 && data_out == '0 && !data_oe)
    else $error("aux buffer data not zero after reset");

  irq_status_reset_a : assert property (
    after_reset |-> half_reg[IDX_CTRL_IRQ_STS] == '0)
    else $error("controller irq status not zero after reset");

  irq_enable_reset_a : assert property (
    after_reset |-> half_reg[IDX_CTRL_IRQ_EN] == '0)
    else $error("controller irq enable not zero after reset");

  usb_irq_reset_a : assert property (
    after_reset |-> word_reg[IDX_USB_IRQ_EN] == '0)
    else $error("usb interrupt enable not zero after reset");

  test_param_reset_a : assert property (
    after_reset |-> word_reg[IDX_TEST_ONE] == '0 && word_reg[IDX_TEST_TWO] == '0)
    else $error("test parameter registers not zero after reset");

  cap_write_ignored_a : assert property (
    write_at(OFF_STRUCTURAL_PARAMS) ##[1:300] read_at(OFF_STRUCTURAL_PARAMS)
    |=> data_out == {12'h000, PORT_COUNT})
    else $error("capability word changed by a write");

  pointer_step_a : assert property (
    write_at(OFF_AUX_BUFFER_DATA) && !ch_fetch[1]
    |=> ch_pointer[1] == $past(ch_pointer[1]) + POINTER_STEP ##1 !ch_fetch[1] ##0 1)
    else $error("aux pointer did not advance one word");

endmodule : usb_host_register_map
`default_nettype wire

// File: pkg/usb_host_reg_pkg.sv
// Purpose: constants, register map and bus carrier for the host controller register bank
// Assumes: 16-bit parallel memory-style bus, byte addresses, even alignment
// Notes:   32-bit registers span two halfwords, low half at the even word offset
package usb_host_reg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // pin bundle sampled from the processor bus
  typedef struct packed {
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_pins_t;

  localparam bus_pins_t BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: '0, data: '0};

  // halfword select inside a 32-bit register
  localparam int HALF_SEL_BIT = 1;

  // fixed capability contents
  localparam logic [15:0] INTERFACE_VERSION  = 16'h0100;
  localparam logic [7:0]  CAPABILITY_LENGTH  = 8'h10;
  localparam logic [3:0]  PORT_COUNT         = 4'h1;
  localparam logic [31:0] CAPABILITY_PARAMS  = 32'h0000_0006;

  // read-only and window offsets
  localparam logic [7:0] OFF_CAP_LENGTH_VERSION = 8'h00;
  localparam logic [7:0] OFF_STRUCTURAL_PARAMS  = 8'h04;
  localparam logic [7:0] OFF_CAPABILITY_PARAMS  = 8'h08;
  localparam logic [7:0] OFF_DEVICE_IDENTITY    = 8'h80;
  localparam logic [7:0] OFF_BUFFER_ADDRESS     = 8'h90;
  localparam logic [7:0] OFF_BUFFER_DATA        = 8'h92;
  localparam logic [7:0] OFF_AUX_BUFFER_ADDRESS = 8'h98;
  localparam logic [7:0] OFF_AUX_BUFFER_DATA    = 8'h9a;
  localparam logic [7:0] OFF_HIGH_HALF          = 8'h02;

  // ordinary 32-bit storage registers
  localparam int WORD_COUNT        = 14;
  localparam int IDX_COMMAND       = 0;
  localparam int IDX_STATUS        = 1;
  localparam int IDX_USB_IRQ_EN    = 2;
  localparam int IDX_FRAME_INDEX   = 3;
  localparam int IDX_PERIODIC      = 4;
  localparam int IDX_ASYNC         = 5;
  localparam int IDX_PORT          = 6;
  localparam int IDX_FRAME_END     = 7;
  localparam int IDX_TEST_MODE     = 8;
  localparam int IDX_TEST_ONE      = 9;
  localparam int IDX_TEST_TWO      = 10;
  localparam int IDX_BUS_MODE      = 11;
  localparam int IDX_EDGE_IRQ      = 12;
  localparam int IDX_SOFT_RESET    = 13;

  localparam logic [7:0] WORD_OFFSET [WORD_COUNT] = '{
    8'h10, 8'h14, 8'h18, 8'h1c, 8'h24, 8'h28, 8'h30,
    8'h34, 8'h50, 8'h70, 8'h74, 8'h84, 8'h88, 8'h8c};

  localparam logic [31:0] WORD_RESET [WORD_COUNT] = '{
    32'h0008_0b00, 32'h0000_1000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0041,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_001f, 32'h0000_0000};

  // ordinary 16-bit storage registers
  localparam int HALF_COUNT       = 5;
  localparam int IDX_XFER_LENGTH  = 0;
  localparam int IDX_CHIP_CONFIG  = 1;
  localparam int IDX_SLEEP_TIMER  = 2;
  localparam int IDX_CTRL_IRQ_STS = 3;
  localparam int IDX_CTRL_IRQ_EN  = 4;

  localparam logic [7:0] HALF_OFFSET [HALF_COUNT] = '{8'h94, 8'h96, 8'h9c, 8'ha0, 8'ha4};

  localparam logic [15:0] HALF_RESET [HALF_COUNT] = '{
    16'h0000, 16'h1fa0, 16'h0400, 16'h0000, 16'h0000};

  // buffer windows: channel 0 primary, channel 1 auxiliary
  localparam int CHANNELS = 2;
  localparam logic [7:0] CH_ADDR_OFF [CHANNELS] = '{OFF_BUFFER_ADDRESS, OFF_AUX_BUFFER_ADDRESS};
  localparam logic [7:0] CH_DATA_OFF [CHANNELS] = '{OFF_BUFFER_DATA, OFF_AUX_BUFFER_DATA};
  localparam logic [15:0] POINTER_STEP = 16'h0002;

endpackage : usb_host_reg_pkg

// File: design/pin_sync.sv
// Purpose: two-stage synchroniser for a bundle of asynchronous pins
// Assumes: each bit is sampled independently
// Notes:   multi-bit fields are only used once their strobe has settled
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE  = '0
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          stage_one[g] <= IDLE[g];
          sync_out[g]  <= IDLE[g];
        end
        else
        begin
          stage_one[g] <= async_in[g];
          sync_out[g]  <= stage_one[g];
        end
      end
    end
  endgenerate

endmodule : pin_sync
`default_nettype wire

// File: sim/host_bus_model.sv
// Purpose: host processor model driving the parallel register bus of the bank
// Assumes: strobes change at the falling clock edge, held well past the sync lag
// Notes:   strobe_len may be raised by the bench to play a slow processor
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
  import usb_host_reg_pkg::*;
(
  // clock
  input  wire logic              ref_clk,
  // pins toward the device
  output var  bus_pins_t         pins,
  output var  logic [DATA_W-1:0] data_wire,
  // device side of the data pins
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe
);
  logic              host_drive;
  logic [DATA_W-1:0] last_wire;
  int                strobe_len;

  initial
  begin
    pins = BUS_IDLE;
    host_drive = 1'b0;
    last_wire = 16'h0000;
    strobe_len = 4;
  end

  // undriven pins toggle every cycle so a stale value never passes
  always @(posedge ref_clk)
    last_wire <= data_wire;

  always_comb
  begin
    if (data_oe)
      data_wire = data_out;
    else if (host_drive)
      data_wire = pins.data;
    else
      data_wire = ~last_wire;
  end

  task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    pins = '{cs_n: 1'b0, rd_n: 1'b1, wr_n: 1'b0, addr: a, data: d};
    host_drive = 1'b1;
    repeat (strobe_len) @(negedge ref_clk);
    pins.wr_n = 1'b1;
    // select stays low past the rising write strobe
    repeat (2) @(negedge ref_clk);
    pins.cs_n = 1'b1;
    host_drive = 1'b0;
    repeat (5) @(negedge ref_clk);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    pins = '{cs_n: 1'b0, rd_n: 1'b0, wr_n: 1'b1, addr: a, data: 16'h0000};
    repeat (strobe_len - 1) @(negedge ref_clk);
    while (data_oe !== 1'b1 && n < 16)
    begin
      @(negedge ref_clk);
      n++;
    end
    d = (data_oe === 1'b1) ? data_out : 'x;
    pins.cs_n = 1'b1;
    pins.rd_n = 1'b1;
    n = 0;
    while (data_oe !== 1'b0 && n < 16)
    begin
      @(negedge ref_clk);
      n++;
    end
    repeat (2) @(negedge ref_clk);
  endtask : bus_read
endmodule : host_bus_model
`default_nettype wire

// File: sim/testbench.sv
// Purpose: self-checking bench for the host controller register bank
// Assumes: bus cycles come from the host model tasks
// Notes:   covers reset values, read-only words, gaps, aux window, mid-run reset
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import usb_host_reg_pkg::*;

  localparam logic [31:0] ID_VALUE = 32'h1234_0007; // arbitrary value

  logic              ref_clk;
  logic              reset_n;
  bus_pins_t         pins;
  logic [DATA_W-1:0] data_wire;
  logic [DATA_W-1:0] data_out;
  logic              data_oe;
  int                error_cnt;
  int                compares;
  logic [15:0]       rd_val;

  // table entries without a dedicated scenario
  logic [7:0]  w_addr [7]  = '{8'h08, 8'h10, 8'h14, 8'h1c, 8'h50, 8'h84, 8'h8c};
  logic [31:0] w_rst  [7]  = '{32'h0000_0006, 32'h0008_0b00, 32'h0000_1000, 32'h0000_0000,
                               32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  logic [7:0]  h_addr [4]  = '{8'h90, 8'h92, 8'h96, 8'h9c};
  logic [15:0] h_rst  [4]  = '{16'h0000, 16'h0000, 16'h1fa0, 16'h0400};
  logic [7:0]  rw_addr [8] = '{8'h18, 8'h24, 8'h28, 8'h30, 8'h34, 8'h70, 8'h74, 8'h88};
  logic [7:0]  ro_addr [8] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h80, 8'h82};

  initial
    ref_clk = 1'b0;

  always #5 ref_clk = ~ref_clk;

  usb_host_register_map #(.DEVICE_IDENTITY(ID_VALUE), .BUF_WORDS(64)) dut_u (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .cs_n     (pins.cs_n),
    .rd_n     (pins.rd_n),
    .wr_n     (pins.wr_n),
    .addr     (pins.addr),
    .data_in  (data_wire),
    .data_out (data_out),
    .data_oe  (data_oe)
  );

  host_bus_model host_u (
    .ref_clk   (ref_clk),
    .pins      (pins),
    .data_wire (data_wire),
    .data_out  (data_out),
    .data_oe   (data_oe)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic check_word(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [15:0] lo;
    logic [15:0] hi;
    host_u.bus_read(a, lo);
    host_u.bus_read(a + 8'h02, hi);
    check(what, {hi, lo}, exp);
  endtask : check_word

  task automatic check_half(input string what, input logic [7:0] a, input logic [15:0] exp);
    host_u.bus_read(a, rd_val);
    check(what, {16'h0000, rd_val}, {16'h0000, exp});
  endtask : check_half

  task automatic pulse_reset();
    @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask : pulse_reset

  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // a hang costs a mismatch and still ends the run through the verdict
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    reset_n = 1'b0;
    error_cnt = 0;
    compares = 0;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("idle_drive", {31'h0, data_oe}, 32'h0);
    check_word("capability_length_version", 8'h00, 32'h0100_0010);
    check_word("structural_parameters", 8'h04, 32'h0000_0001);
    check_word("periodic_list_base", 8'h24, 32'h0000_0000);
    check_word("async_list_pointer", 8'h28, 32'h0000_0000);
    check_word("port_status_control", 8'h30, 32'h0000_0000);
    check_word("frame_end_timing", 8'h34, 32'h0000_0041);
    check_word("edge_irq_control", 8'h88, 32'h0000_001f);
    check_half("transfer_length", 8'h94, 16'h0000);
    check_half("aux_buffer_address", 8'h98, 16'h0000);
    check_half("aux_buffer_data", 8'h9a, 16'h0000);
    check_half("controller_irq_status", 8'ha0, 16'h0000);
    check_half("controller_irq_enable", 8'ha4, 16'h0000);
    check_word("usb_interrupt_enable", 8'h18, 32'h0000_0000);
    check_word("test_parameter_one", 8'h70, 32'h0000_0000);
    check_word("test_parameter_two", 8'h74, 32'h0000_0000);
    check_word("device_identity", 8'h80, ID_VALUE);
    for (int i = 0; i < 7; i++)
      check_word("word_reset", w_addr[i], w_rst[i]);
    for (int i = 0; i < 4; i++)
      check_half("half_reset", h_addr[i], h_rst[i]);
    // slow processor for the storage pass
    host_u.strobe_len = 8;
    for (int i = 0; i < 8; i++)
    begin
      host_u.bus_write(rw_addr[i], {8'h5a, rw_addr[i]});
      host_u.bus_write(rw_addr[i] + 8'h02, {8'hc3, rw_addr[i]});
      check_word("word_storage", rw_addr[i], {8'hc3, rw_addr[i], 8'h5a, rw_addr[i]});
    end
    host_u.strobe_len = 4;
    host_u.bus_write(8'h94, 16'h0123);
    host_u.bus_write(8'ha4, 16'h00ff);
    check_half("transfer_length", 8'h94, 16'h0123);
    check_half("controller_irq_enable", 8'ha4, 16'h00ff);
    for (int i = 0; i < 8; i++)
      host_u.bus_write(ro_addr[i], 16'hffff);
    check_word("capability_length_version", 8'h00, 32'h0100_0010);
    check_word("structural_parameters", 8'h04, 32'h0000_0001);
    check_word("capability_parameters", 8'h08, 32'h0000_0006);
    check_word("device_identity", 8'h80, ID_VALUE);
    host_u.bus_write(8'h0c, 16'hffff);
    check_half("unmapped_gap", 8'h0c, 16'h0000);
    // aux window: store, pointer steps, refetch after pointer rewrite
    host_u.bus_write(8'h98, 16'h0010);
    host_u.bus_write(8'h9a, 16'hbeef);
    check_half("aux_buffer_address", 8'h98, 16'h0012);
    host_u.bus_write(8'h98, 16'h0010);
    check_half("aux_buffer_data", 8'h9a, 16'hbeef);
    check_half("aux_buffer_address", 8'h98, 16'h0012);
    // primary window, kept apart from the aux word so a shared index shows
    host_u.bus_write(8'h90, 16'h0020);
    host_u.bus_write(8'h92, 16'h1357);
    host_u.bus_write(8'h90, 16'h0020);
    check_half("buffer_data_window", 8'h92, 16'h1357);
    check_half("buffer_address_pointer", 8'h90, 16'h0022);
    // second reset in mid-run must restore the documented values
    pulse_reset();
    check_word("periodic_list_base", 8'h24, 32'h0000_0000);
    check_word("frame_end_timing", 8'h34, 32'h0000_0041);
    check_word("edge_irq_control", 8'h88, 32'h0000_001f);
    check_half("transfer_length", 8'h94, 16'h0000);
    check_half("aux_buffer_address", 8'h98, 16'h0000);
    check_half("aux_buffer_data", 8'h9a, 16'h0000);
    check_half("controller_irq_enable", 8'ha4, 16'h0000);
    check_word("usb_interrupt_enable", 8'h18, 32'h0000_0000);
    check_word("test_parameter_two", 8'h74, 32'h0000_0000);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
